// [hdl/mac_pkg.sv]
// Purpose: Shared constants for the 16x16 multiplier-accumulator block
// Assumes: 32-bit AHB-Lite register window, word-aligned registers
// Notes:   Byte addresses are the offsets below
package mac_pkg;
  localparam int OPERAND_W  = 16;
  localparam int GUARD_W    = 3;
  localparam int RESULT_W   = 35;
  localparam int EXT_W      = OPERAND_W + 1;
  localparam int GUARD_LSB  = 32;
  localparam int UPPER_LSB  = 16;
  localparam int ROUND_BIT  = 15;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_CNT_W = 3;

  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] STATUS_OFS  = 8'h04;
  localparam logic [7:0] LIVE_LO_OFS = 8'h08;
  localparam logic [7:0] LIVE_HI_OFS = 8'h0C;
  localparam logic [7:0] FIFO_LO_OFS = 8'h10;
  localparam logic [7:0] FIFO_HI_OFS = 8'h14;

  localparam int STAT_EMPTY_BIT = 0;
  localparam int STAT_FULL_BIT  = 1;
  localparam int STAT_CNT_LSB   = 2;
  localparam int STAT_MODE_LSB  = 5;
  localparam int CTRL_CAPT_BIT  = 0;

  localparam logic [31:0]        CTRL_RESET   = 32'h0000_0000;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 35'h0_0000_0000;
  localparam logic [1:0]          HTRANS_NONSEQ = 2'h2;
endpackage

// [hdl/mac_16x16_accumulator.sv]
// Purpose: Multiplier-accumulator with sectioned three-state result port and AHB-Lite view
// Assumes: Operand and result clocks arrive as strobes synchronous to clk
// Notes:   Results may be captured into a 4-word FIFO drained by software
//
// Summary of operation
// - 35-bit sum split guard/upper/lower words
// - Guard word MSB is sign when signed
// - X, Y and result registers load independently
// - Mode controls captured on OR of operand clocks
// - Section drives pins when its hiz low and pin loading off
// - Pin loading floats all three sections
// - Pin loading takes pins into sections whose hiz high
// - Pin loading holds sections whose hiz low
// - Hiz and pin-load controls act unregistered
// - Rounding adds one at lower word MSB
// - Signed format selects two's complement operands
// - Accumulate without subtract adds previous result to product
// - No accumulate stores bare product
// - Subtract with accumulate stores product minus previous result
// - Lower word shares pins with Y operand
// - Operands 16 bits, bit 15 sign
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module result_fifo #(
  parameter int WIDTH = 35,
  parameter int DEPTH = 4,
  parameter int CNT_W = 3
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [CNT_W-1:0]      level
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PTR_W-1:0] wr_ptr_r;
  logic [PTR_W-1:0] rd_ptr_r;
  logic [CNT_W-1:0] cnt_r;
  logic             push;
  logic             pop;

  assign push      = in_valid && (cnt_r != FULL_CNT);
  assign pop       = out_ready && (cnt_r != '0);
  assign in_ready  = (cnt_r != FULL_CNT);
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rd_ptr_r];
  assign level     = cnt_r;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= PTR_W'((wr_ptr_r + 1'b1) % DEPTH);
      end
      if (pop) begin
        rd_ptr_r <= PTR_W'((rd_ptr_r + 1'b1) % DEPTH);
      end
      cnt_r <= cnt_r + CNT_W'(push) - CNT_W'(pop);
    end
  end
endmodule // result_fifo

////////////////////////////////////////////////////////////////////////////////
module mac_16x16_accumulator (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        clk_x,
  input  wire logic        clk_y,
  input  wire logic        clk_p,
  input  wire logic [15:0] x_in,
  input  wire logic        round_select,
  input  wire logic        signed_format,
  input  wire logic        sum_with_previous,
  input  wire logic        subtract_previous,
  input  wire logic        load_from_pins,
  input  wire logic        guard_word_hiz,
  input  wire logic        upper_word_hiz,
  input  wire logic        lower_word_hiz,
  input  wire logic [2:0]  guard_word_in,
  output logic      [2:0]  guard_word_out,
  output logic             guard_word_oe,
  input  wire logic [15:0] upper_word_in,
  output logic      [15:0] upper_word_out,
  output logic             upper_word_oe,
  input  wire logic [15:0] lower_word_in,
  output logic      [15:0] lower_word_out,
  output logic             lower_word_oe,
  output logic             result_fifo_ready,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp
);
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_DATA = 1'b1
  } bus_state_e;

  localparam int RW = mac_pkg::RESULT_W;
  localparam int EW = mac_pkg::EXT_W;

  logic [15:0]    x_r;
  logic [15:0]    y_r;
  logic           clk_x_d_r;
  logic           clk_y_d_r;
  logic           clk_p_d_r;
  logic           ctl_or_d_r;
  logic           round_r;
  logic           signed_r;
  logic           accum_r;
  logic           sub_r;
  logic [RW-1:0]  result_r;
  logic [RW-1:0]  result_nxt;
  logic [RW-1:0]  product;
  logic [RW-1:0]  prod_round;
  logic [2*EW-1:0] wide_prod;
  logic           x_edge;
  logic           y_edge;
  logic           p_edge;
  logic           ctl_edge;
  logic [31:0]    ctrl_r;
  bus_state_e     bus_r;
  logic [7:0]     addr_r;
  logic           wr_r;
  logic           fifo_pop;
  logic [RW-1:0]  fifo_data;
  logic           fifo_valid;
  logic           fifo_in_ready;
  logic [2:0]     fifo_level;
  logic [31:0]    rd_mux;

  ////////////////////////////////////////////////////////////////////////////////
  // Strobe edges; host keeps operand strobes low between pulses
  assign x_edge   = clk_x && !clk_x_d_r;
  assign y_edge   = clk_y && !clk_y_d_r;
  assign p_edge   = clk_p && !clk_p_d_r;
  assign ctl_edge = (clk_x || clk_y) && !ctl_or_d_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clk_x_d_r  <= 1'b0;
      clk_y_d_r  <= 1'b0;
      clk_p_d_r  <= 1'b0;
      ctl_or_d_r <= 1'b0;
    end else begin
      clk_x_d_r  <= clk_x;
      clk_y_d_r  <= clk_y;
      clk_p_d_r  <= clk_p;
      ctl_or_d_r <= clk_x || clk_y;
    end
  end

  // Y operand comes in over the lower-word pins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      x_r <= 16'h0000;
      y_r <= 16'h0000;
    end else begin
      if (x_edge) begin
        x_r <= x_in;
      end
      if (y_edge) begin
        y_r <= lower_word_in;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      round_r  <= 1'b0;
      signed_r <= 1'b0;
      accum_r  <= 1'b0;
      sub_r    <= 1'b0;
    end else if (ctl_edge) begin
      round_r  <= round_select;
      signed_r <= signed_format;
      accum_r  <= sum_with_previous;
      sub_r    <= subtract_previous;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Arithmetic: one extra operand bit lets a single signed multiplier serve both formats
  assign wide_prod  = (2*EW)'($signed({signed_r && x_r[15], x_r})) *
                      (2*EW)'($signed({signed_r && y_r[15], y_r}));
  assign product    = {wide_prod[2*EW-1], wide_prod[RW-2:0]};
  assign prod_round = product + (RW'(round_r) << mac_pkg::ROUND_BIT);

  always_comb begin
    if (!accum_r) begin
      result_nxt = prod_round;
    end else if (sub_r) begin
      result_nxt = prod_round - result_r;
    end else begin
      result_nxt = prod_round + result_r;
    end
  end

  // Each section either reloads, takes its pins, or holds during pin loading
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_r <= mac_pkg::RESULT_RESET;
    end else if (p_edge) begin
      if (!load_from_pins) begin
        result_r <= result_nxt;
      end else begin
        if (guard_word_hiz) begin
          result_r[RW-1:mac_pkg::GUARD_LSB] <= guard_word_in;
        end
        if (upper_word_hiz) begin
          result_r[mac_pkg::GUARD_LSB-1:mac_pkg::UPPER_LSB] <= upper_word_in;
        end
        if (lower_word_hiz) begin
          result_r[mac_pkg::UPPER_LSB-1:0] <= lower_word_in;
        end
      end
    end
  end

  assign guard_word_out = result_r[RW-1:mac_pkg::GUARD_LSB];
  assign upper_word_out = result_r[mac_pkg::GUARD_LSB-1:mac_pkg::UPPER_LSB];
  assign lower_word_out = result_r[mac_pkg::UPPER_LSB-1:0];
  // Enables stay combinational so a bus turnaround needs no result clock
  assign guard_word_oe  = !load_from_pins && !guard_word_hiz;
  assign upper_word_oe  = !load_from_pins && !upper_word_hiz;
  assign lower_word_oe  = !load_from_pins && !lower_word_hiz;

  ////////////////////////////////////////////////////////////////////////////////
  // Each computed result (not a pin load) is offered to the FIFO while CTRL bit 0 is set; a full FIFO drops it and shows not-ready
  result_fifo #(
    .WIDTH (RW),
    .DEPTH (mac_pkg::FIFO_DEPTH),
    .CNT_W (mac_pkg::FIFO_CNT_W)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_data   (result_nxt),
    .in_valid  (p_edge && !load_from_pins && ctrl_r[mac_pkg::CTRL_CAPT_BIT]),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .level     (fifo_level)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_fifo_ready <= 1'b0;
    end else begin
      result_fifo_ready <= fifo_in_ready;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: one wait state so read data comes from a flip-flop
  assign fifo_pop = (bus_r == BUS_DATA) && !wr_r && (addr_r == mac_pkg::FIFO_HI_OFS)
                    && fifo_valid;

  always_comb begin
    unique case (addr_r)
      mac_pkg::CTRL_OFS:    rd_mux = ctrl_r;
      mac_pkg::STATUS_OFS:  rd_mux = {23'h00_0000, sub_r, accum_r, signed_r, round_r,
                                      fifo_level, !fifo_in_ready, !fifo_valid};
      mac_pkg::LIVE_LO_OFS: rd_mux = result_r[31:0];
      mac_pkg::LIVE_HI_OFS: rd_mux = {29'h0000_0000, result_r[RW-1:32]};
      mac_pkg::FIFO_LO_OFS: rd_mux = fifo_data[31:0];
      mac_pkg::FIFO_HI_OFS: rd_mux = {29'h0000_0000, fifo_data[RW-1:32]};
      default:              rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_r     <= BUS_IDLE;
      addr_r    <= 8'h00;
      wr_r      <= 1'b0;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
      ctrl_r    <= mac_pkg::CTRL_RESET;
    end else begin
      unique case (bus_r)
        BUS_IDLE: begin
          if (hsel && hready && htrans == mac_pkg::HTRANS_NONSEQ) begin
            bus_r     <= BUS_DATA;
            addr_r    <= {haddr[7:2], 2'b00};
            wr_r      <= hwrite;
            hreadyout <= 1'b0;
          end
        end
        BUS_DATA: begin
          bus_r     <= BUS_IDLE;
          hreadyout <= 1'b1;
          if (wr_r) begin
            if (addr_r == mac_pkg::CTRL_OFS) begin
              ctrl_r <= {31'h0000_0000, hwdata[mac_pkg::CTRL_CAPT_BIT]};
            end
          end else begin
            hrdata <= rd_mux;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  chk_preload_float: assert property (@(posedge clk) disable iff (rst)
    load_from_pins |-> !guard_word_oe && !upper_word_oe && !lower_word_oe)
    else $error("pin loading left a driver on");

  chk_section_drive: assert property (@(posedge clk) disable iff (rst)
    (!load_from_pins && !lower_word_hiz) |-> lower_word_oe)
    else $error("lower word not driven while enabled");

  chk_preload_take: assert property (@(posedge clk) disable iff (rst)
    (p_edge && load_from_pins && guard_word_hiz) |=> guard_word_out == $past(guard_word_in))
    else $error("guard word not loaded from pins");

  chk_preload_hold: assert property (@(posedge clk) disable iff (rst)
    (p_edge && load_from_pins && !upper_word_hiz) |=> $stable(upper_word_out))
    else $error("driven section changed during pin loading");

  chk_direct_store: assert property (@(posedge clk) disable iff (rst)
    (p_edge && !load_from_pins && !accum_r) |=> result_r == $past(prod_round))
    else $error("bare product not stored");

  chk_accum_add: assert property (@(posedge clk) disable iff (rst)
    (p_edge && !load_from_pins && accum_r && !sub_r)
      |=> result_r == RW'($past(prod_round) + $past(result_r)))
    else $error("accumulate sum wrong");

  chk_accum_sub: assert property (@(posedge clk) disable iff (rst)
    (p_edge && !load_from_pins && accum_r && sub_r)
      |=> result_r == RW'($past(prod_round) - $past(result_r)))
    else $error("subtract order wrong");

  chk_ctrl_capture: assert property (@(posedge clk) disable iff (rst)
    ctl_edge |=> (round_r == $past(round_select)) && (sub_r == $past(subtract_previous)))
    else $error("mode controls not captured");

  chk_x_load: assert property (@(posedge clk) disable iff (rst)
    x_edge |=> x_r == $past(x_in))
    else $error("X operand not loaded");

  chk_bus_answer: assert property (@(posedge clk) disable iff (rst)
    (bus_r == BUS_IDLE && hsel && hready && htrans == mac_pkg::HTRANS_NONSEQ)
      |=> !hreadyout ##1 hreadyout && !hresp)
    else $error("bus answer timing wrong");
endmodule // mac_16x16_accumulator

// [verification/host_bus_model.sv]
// Purpose: Host datapath model on the shared result and Y operand pins
// Assumes: Device oe high means the device drives that section
// Notes:   Bits nobody drives show the inverse of their last level, so stale data never passes
`timescale 1ns/1ps
////////////////////////////////////////
module host_bus_model (
  input  wire logic        clk,
  input  wire logic        host_oe,
  input  wire logic [34:0] host_val,
  input  wire logic [2:0]  guard_word_out,
  input  wire logic        guard_word_oe,
  input  wire logic [15:0] upper_word_out,
  input  wire logic        upper_word_oe,
  input  wire logic [15:0] lower_word_out,
  input  wire logic        lower_word_oe,
  output logic      [2:0]  guard_word_in,
  output logic      [15:0] upper_word_in,
  output logic      [15:0] lower_word_in
);
  logic [34:0] den;
  logic [34:0] lvl;
  logic [34:0] last_r = '0;
  assign den = {{3{guard_word_oe}}, {16{upper_word_oe}}, {16{lower_word_oe}}};
  // Host yields wherever the device drives, so Y never fights the lower word
  assign lvl = (den & {guard_word_out, upper_word_out, lower_word_out})
             | (~den & (host_oe ? host_val : ~last_r));
  assign {guard_word_in, upper_word_in, lower_word_in} = lvl;
  always_ff @(posedge clk) last_r <= lvl;
endmodule // host_bus_model

// [verification/mac_16x16_accumulator_tb.sv]
// Purpose: Self-checking bench for the multiplier-accumulator
// Assumes: Strobes are sampled on clk; bus reads are scored from a queue
// Notes:   Expected results come from a behavioural sum kept here
`timescale 1ns/1ps
////////////////////////////////////////
module mac_16x16_accumulator_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        clk_x = 1'b0;
  logic        clk_y = 1'b0;
  logic        clk_p = 1'b0;
  logic [15:0] x_in = 16'h0;
  logic        round_in = 1'b0;
  logic        sgn = 1'b0;
  logic        accum_in = 1'b0;
  logic        sub = 1'b0;
  logic        lp = 1'b0;
  logic [2:0]  hz = 3'h0;
  logic        host_oe = 1'b0;
  logic [34:0] host_val = 35'h0;
  logic [2:0]  gi, go;
  logic [15:0] ui, uo, li, lo;
  logic        goe, uoe, loe, fifo_rdy, hreadyout, hresp;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        rd_ph = 1'b0;
  logic        cap = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [34:0] m = 35'h0;
  logic [34:0] hv, mk, e;
  logic [3:0]  mdl = 4'h0;
  logic [31:0] q[$];
  logic [34:0] fq[$];
  int          error_cnt = 0;
  int          samples_checked = 0;

  mac_16x16_accumulator i_mac_16x16_accumulator (
    .clk(clk), .rst(rst), .clk_x(clk_x), .clk_y(clk_y), .clk_p(clk_p), .x_in(x_in),
    .round_select(round_in), .signed_format(sgn), .sum_with_previous(accum_in),
    .subtract_previous(sub), .load_from_pins(lp), .guard_word_hiz(hz[2]),
    .upper_word_hiz(hz[1]), .lower_word_hiz(hz[0]), .guard_word_in(gi),
    .guard_word_out(go), .guard_word_oe(goe), .upper_word_in(ui), .upper_word_out(uo),
    .upper_word_oe(uoe), .lower_word_in(li), .lower_word_out(lo), .lower_word_oe(loe),
    .result_fifo_ready(fifo_rdy), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));

  host_bus_model i_host_bus_model (
    .clk(clk), .host_oe(host_oe), .host_val(host_val), .guard_word_out(go),
    .guard_word_oe(goe), .upper_word_out(uo), .upper_word_oe(uoe), .lower_word_out(lo),
    .lower_word_oe(loe), .guard_word_in(gi), .upper_word_in(ui), .lower_word_in(li));

  initial forever #10 clk = ~clk;
  initial begin
    #(20 * 20000);
    error_cnt++;
    test_done();
  end
////////////////////////////////////////
  task automatic chk(input logic [34:0] got, input logic [34:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
    chk({3'h0, got}, {3'h0, exp});
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= mac_pkg::HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= !w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd_ph <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    q.push_back(exp);
    bus(1'b0, a, 32'h0);
  endtask
  // Read data is taken at the edge that ends the data phase
  always @(posedge clk) begin
    if (rd_ph && hreadyout === 1'b1) begin
      chk_bus(hrdata, q.pop_front());
      chk(35'(hresp), 35'h0);
    end
  end
  task automatic op(input logic [15:0] x, input logic [15:0] y, input logic [3:0] md);
    logic [34:0] p;
    @(posedge clk);
    x_in <= x;
    {sub, accum_in, sgn, round_in} <= md;
    clk_x <= 1'b1;
    hz[0] <= 1'b1;
    host_oe <= 1'b1;
    host_val <= {19'h0, y};
    @(posedge clk);
    clk_x <= 1'b0;
    clk_y <= 1'b1;
    @(posedge clk);
    clk_y <= 1'b0;
    clk_p <= 1'b1;
    @(posedge clk);
    clk_p <= 1'b0;
    host_oe <= 1'b0;
    if (md[1]) p = $signed(x) * $signed(y);
    else p = x * y;
    m = md[2] ? (md[3] ? p - m : p + m) : p;
    if (md[0]) m = m + 35'h0_0000_8000;
    mdl = md;
    if (cap && fq.size() < mac_pkg::FIFO_DEPTH) fq.push_back(m);
    #1 chk({go, uo, lo}, m);
    rd(mac_pkg::LIVE_LO_OFS, m[31:0]);
    rd(mac_pkg::LIVE_HI_OFS, {29'h0, m[34:32]});
  endtask
  task automatic test_done();
    $display("Checks %0d, errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
////////////////////////////////////////
  initial begin
    void'($urandom(32'h9FE7));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    #1 chk({go, uo, lo}, mac_pkg::RESULT_RESET);
    rd(mac_pkg::CTRL_OFS, mac_pkg::CTRL_RESET);
    // Checked in the same cycle, so a registered control would lag and fail
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      {lp, hz} <= 4'(i);
      @(negedge clk);
      chk(35'({goe, uoe, loe}), 35'({3{!lp}} & ~hz));
    end
    @(posedge clk);
    lp <= 1'b0;
    hz <= 3'h0;
    op(16'h1234, 16'h0056, 4'h0);
    op(16'h0003, 16'h0004, 4'h4);
    op(16'h0002, 16'h0003, 4'hC);
    op(16'h8000, 16'h7FFF, 4'h3);
    repeat (9) op(16'hFFFF, 16'hFFFF, 4'h4);
    repeat (12) op(16'($urandom()), 16'($urandom()), 4'($urandom()));
    for (int i = 1; i < 8; i++) begin
      hv = 35'({$urandom(), $urandom()});
      mk = {{3{i[2]}}, {16{i[1]}}, {16{i[0]}}};
      @(posedge clk);
      lp <= 1'b1;
      hz <= 3'(i);
      host_oe <= 1'b1;
      host_val <= hv;
      @(posedge clk);
      clk_p <= 1'b1;
      @(posedge clk);
      clk_p <= 1'b0;
      m = (m & ~mk) | (hv & mk);
      #1 chk({go, uo, lo}, m);
    end
    @(posedge clk);
    lp <= 1'b0;
    host_oe <= 1'b0;
    hz <= 3'h0;
    rd(mac_pkg::LIVE_LO_OFS, m[31:0]);
    bus(1'b1, mac_pkg::CTRL_OFS, 32'h1);
    cap = 1'b1;
    rd(mac_pkg::CTRL_OFS, 32'h1);
    repeat (6) op(16'($urandom()), 16'($urandom()), 4'($urandom()));
    chk(35'(fifo_rdy), 35'h0);
    rd(mac_pkg::STATUS_OFS, {23'h0, mdl, 3'h4, 2'h2});
    bus(1'b1, mac_pkg::STATUS_OFS, 32'hFFFF_FFFF);
    rd(8'h18, 32'h0);
    repeat (4) begin
      e = fq.pop_front();
      rd(mac_pkg::FIFO_LO_OFS, e[31:0]);
      rd(mac_pkg::FIFO_HI_OFS, {29'h0, e[34:32]});
    end
    rd(mac_pkg::STATUS_OFS, {23'h0, mdl, 3'h0, 2'h1});
    chk(35'(fifo_rdy), 35'h1);
    test_done();
  end
endmodule // mac_16x16_accumulator_tb
